// ==== hw/sbst_buf_mem.sv ====
// payload store, one word per translator buffer, registered read
`timescale 1ns/1ps
module sbst_buf_mem #(
    parameter int DEPTH = 2,
    parameter int WIDTH = 32,
    parameter int AW    = 1
) (
    input  wire logic             clk,     // system clock
    input  wire logic             rst,     // sync reset, high
    input  wire logic             ce,      // clock enable
    input  wire logic             we,      // write strobe
    input  wire logic [AW-1:0]    waddr,   // write index
    input  wire logic [WIDTH-1:0] wdata,   // write word
    input  wire logic             re,      // read strobe
    input  wire logic [AW-1:0]    raddr,   // read index
    output logic      [WIDTH-1:0] rdata_q  // read word, one cycle after re
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_d;

    if (DEPTH < 1 || (1 << AW) < DEPTH) begin : g_bad
        $error("sbst_buf_mem: bad depth or index width");
    end

    always_comb begin
        rdata_d = rdata_q;
        if (re) begin
            rdata_d = mem_q[raddr];
        end
    end

    // payload words carry no reset, only the read register does
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

endmodule // sbst_buf_mem

// ==== hw/sbst_defines.svh ====
// constants for the split buffer status tracker: map, field positions, reset values
`ifndef SBST_DEFINES_SVH
`define SBST_DEFINES_SVH

`define SBST_NUM_BUFS       2
`define SBST_DATA_W         32
`define SBST_ADDR_W         8
`define SBST_ERR_W          8

`define SBST_OFF_CTRL       8'h00
`define SBST_OFF_COUNT      8'h04
`define SBST_OFF_BUF0       8'h10

`define SBST_CTRL_EN_BIT    0
`define SBST_CTRL_EN_RST    1'b1

`define SBST_COUNT_PEND_LSB 0
`define SBST_COUNT_RDY_LSB  8

`define SBST_BUF_STAT_LSB   0
`define SBST_BUF_RES_LSB    4
`define SBST_BUF_KEY_LSB    8

`endif

// ==== hw/sbst_pkg.sv ====
// types shared by the split buffer status tracker
package sbst_pkg;

    typedef enum logic [2:0] {
        ST_OLD     = 3'h1,
        ST_PENDING = 3'h2,
        ST_READY   = 3'h4
    } sbst_stat_e;

    typedef enum logic [3:0] {
        RES_NONE      = 4'h0,
        RES_NAK       = 4'h1,
        RES_TRANS_ERR = 4'h2,
        RES_ACK       = 4'h3,
        RES_STALL     = 4'h4,
        RES_DATA      = 4'h5,
        RES_LASTDATA  = 4'h6,
        RES_MOREDATA  = 4'h7
    } sbst_res_e;

    typedef enum logic [1:0] {
        EP_BULK = 2'h0,
        EP_CTRL = 2'h1,
        EP_INT  = 2'h2,
        EP_ISO  = 2'h3
    } sbst_ep_e;

    typedef enum logic [2:0] {
        EV_NAK     = 3'h0,
        EV_ACK     = 3'h1,
        EV_STALL   = 3'h2,
        EV_DATA_OK = 3'h3,
        EV_PKT_END = 3'h4,
        EV_UFRAME  = 3'h5,
        EV_ERR     = 3'h6
    } sbst_ev_e;

    typedef enum logic [1:0] {
        SS_NAK       = 2'h0,
        SS_ACK_NEW   = 2'h1,
        SS_ACK_RETRY = 2'h2
    } sbst_ss_e;

    typedef struct packed {
        logic [6:0] dev_addr;
        logic [3:0] endpt;
        logic       dir_in;
        sbst_ep_e   ep_type;
        logic       low_speed;
    } sbst_key_s;

    typedef struct packed {
        sbst_stat_e status;
        sbst_res_e  result;
    } sbst_rsp_s;

    // err bits: 0 pid_check_bits, 1 crc5, 2 bad pid, 3 timeout,
    // 4 crc16, 5 bad length, 6 bit stuff, 7 false eop
    typedef struct packed {
        sbst_ev_e    kind;
        logic [7:0]  err;
        logic [31:0] data;
    } sbst_fs_ev_s;

endpackage

// ==== hw/sbst_tracker.sv ====
// split buffer status tracker: per-buffer status and result, apb view
`timescale 1ns/1ps
`include "sbst_defines.svh"
module sbst_tracker import sbst_pkg::*; #(
    parameter int NUM_BUFS = `SBST_NUM_BUFS,
    parameter int DATA_W   = `SBST_DATA_W
) (
    input  wire logic                    clk,          // 25 MHz clock
    input  wire logic                    rst,          // sync reset, high
    input  wire logic                    ce,           // freezes all state when low
    input  wire logic                    psel,         // apb select
    input  wire logic                    penable,      // apb access phase
    input  wire logic                    pwrite,       // apb write
    input  wire logic [`SBST_ADDR_W-1:0] paddr,        // apb byte address
    input  wire logic [31:0]             pwdata,       // apb write data
    output logic      [31:0]             prdata,       // apb read data
    output logic                         pready,       // apb ready
    output logic                         pslverr,      // apb error
    input  wire logic                    ss_valid,     // start-split offered
    input  wire sbst_key_s               ss_key,       // its endpoint key
    output sbst_ss_e                     ss_answer,    // nak, ack new, ack retry
    output logic [$clog2(NUM_BUFS)-1:0]  ss_idx,       // buffer chosen
    input  wire logic                    cs_valid,     // complete-split offered
    input  wire sbst_key_s               cs_key,       // its endpoint key
    output logic                         cs_rsp_valid, // reply strobe
    output logic                         cs_rsp_hit,   // a buffer matched
    output sbst_rsp_s                    cs_rsp,       // status and result
    output logic      [DATA_W-1:0]       cs_data,      // stored in payload
    output logic                         fs_req_valid, // a buffer is pending
    output logic [$clog2(NUM_BUFS)-1:0]  fs_req_idx,   // lowest pending buffer
    output sbst_key_s                    fs_req_key,   // its key
    input  wire logic                    fs_ev_valid,  // downstream outcome
    input  wire logic [$clog2(NUM_BUFS)-1:0] fs_ev_idx, // buffer it belongs to
    input  wire sbst_fs_ev_s             fs_ev         // outcome and payload
);

    localparam int IDX_W = $clog2(NUM_BUFS);

    if (NUM_BUFS < 2 || NUM_BUFS > 32 || DATA_W != 32) begin : g_bad
        $error("sbst_tracker: NUM_BUFS 2..32 and DATA_W 32 only");
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer state

    sbst_stat_e    stat_q [NUM_BUFS];
    sbst_stat_e    stat_d [NUM_BUFS];
    sbst_res_e     res_q  [NUM_BUFS];
    sbst_res_e     res_d  [NUM_BUFS];
    sbst_key_s     key_q  [NUM_BUFS];
    sbst_key_s     key_d  [NUM_BUFS];
    logic [NUM_BUFS-1:0] ss_match;
    logic [NUM_BUFS-1:0] cs_match;
    logic [NUM_BUFS-1:0] is_old;
    logic [NUM_BUFS-1:0] is_pend;
    logic [NUM_BUFS-1:0] is_rdy;
    logic [IDX_W-1:0]    cs_idx;
    logic                cs_hit;
    logic                cs_take;
    logic                ss_take_new;
    logic                ss_retry;
    logic                ev_ok;
    logic                ev_apply;
    sbst_res_e           ev_res;
    logic                ctrl_en_q;
    logic                ctrl_en_d;

    // control endpoints ignore direction; speed never enters the match
    function automatic logic key_match(sbst_key_s a, sbst_key_s b);
        return a.dev_addr == b.dev_addr && a.endpt == b.endpt &&
               (a.ep_type == EP_CTRL || a.dir_in == b.dir_in);
    endfunction

    function automatic logic [IDX_W-1:0] first_one(logic [NUM_BUFS-1:0] v);
        first_one = '0;
        for (int i = NUM_BUFS - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_one = IDX_W'(i);
            end
        end
    endfunction

    function automatic sbst_res_e ev_result(sbst_fs_ev_s e, sbst_ep_e t);
        logic per;
        per = (t == EP_INT || t == EP_ISO);
        ev_result = RES_NONE;
        if (e.kind == EV_ERR || |e.err) begin
            ev_result = RES_TRANS_ERR;
        end else begin
            case (e.kind)
                EV_NAK:     ev_result = RES_NAK;
                EV_ACK:     ev_result = RES_ACK;
                EV_STALL:   ev_result = RES_STALL;
                EV_DATA_OK: ev_result = per ? RES_NONE : RES_DATA;
                EV_PKT_END: ev_result = per ? RES_LASTDATA : RES_NONE;
                EV_UFRAME:  ev_result = per ? RES_MOREDATA : RES_NONE;
                default:    ev_result = RES_NONE;
            endcase
        end
    endfunction

    for (genvar gi = 0; gi < NUM_BUFS; gi++) begin : g_buf
        assign is_old[gi]   = stat_q[gi] == ST_OLD;
        assign is_pend[gi]  = stat_q[gi] == ST_PENDING;
        assign is_rdy[gi]   = stat_q[gi] == ST_READY;
        assign ss_match[gi] = key_match(ss_key, key_q[gi]);
        assign cs_match[gi] = key_match(cs_key, key_q[gi]);
    end

    // start-split placement: a matching buffer first, else lowest old one
    always_comb begin
        ss_idx    = '0;
        ss_answer = SS_NAK;
        if (|ss_match) begin
            ss_idx    = first_one(ss_match);
            ss_answer = is_old[ss_idx] ? SS_ACK_NEW : SS_ACK_RETRY;
        end else if (|is_old) begin
            ss_idx    = first_one(is_old);
            ss_answer = SS_ACK_NEW;
        end
        if (!ctrl_en_q) begin
            ss_answer = SS_NAK;
        end
    end

    assign ss_take_new = ss_valid && ss_answer == SS_ACK_NEW;
    assign ss_retry    = ss_valid && ss_answer == SS_ACK_RETRY;
    assign cs_idx      = first_one(cs_match);
    assign cs_hit      = |cs_match;
    assign cs_take     = cs_valid && cs_hit && is_rdy[cs_idx];
    assign ev_ok       = fs_ev_valid && is_pend[fs_ev_idx];
    assign ev_res      = ev_result(fs_ev, key_q[fs_ev_idx].ep_type);
    assign ev_apply    = ev_ok && ev_res != RES_NONE;

    // the three movers only touch old, ready and pending buffers in turn,
    // so they never collide on one buffer
    always_comb begin
        stat_d = stat_q;
        res_d  = res_q;
        key_d  = key_q;
        if (ss_take_new) begin
            stat_d[ss_idx] = ST_PENDING;
            res_d[ss_idx]  = RES_NONE;
            key_d[ss_idx]  = ss_key;
        end
        if (cs_take) begin
            stat_d[cs_idx] = ST_OLD;
        end
        if (ev_apply) begin
            stat_d[fs_ev_idx] = ST_READY;
            res_d[fs_ev_idx]  = ev_res;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_BUFS; i++) begin
                stat_q[i] <= ST_OLD;
                res_q[i]  <= RES_NONE;
                key_q[i]  <= '0;
            end
        end else if (ce) begin
            stat_q <= stat_d;
            res_q  <= res_d;
            key_q  <= key_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // complete-split reply and downstream request

    logic      cs_rsp_valid_q;
    logic      cs_rsp_hit_q;
    sbst_rsp_s cs_rsp_q;
    sbst_rsp_s cs_rsp_d;

    always_comb begin
        cs_rsp_d = cs_rsp_q;
        if (cs_valid) begin
            cs_rsp_d = '{status: stat_q[cs_idx], result: res_q[cs_idx]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_rsp_valid_q <= 1'b0;
            cs_rsp_hit_q   <= 1'b0;
            cs_rsp_q       <= '{status: ST_OLD, result: RES_NONE};
        end else if (ce) begin
            cs_rsp_valid_q <= cs_valid;
            cs_rsp_hit_q   <= cs_valid && cs_hit;
            cs_rsp_q       <= cs_rsp_d;
        end
    end

    assign cs_rsp_valid = cs_rsp_valid_q;
    assign cs_rsp_hit   = cs_rsp_hit_q;
    assign cs_rsp       = cs_rsp_q;
    assign fs_req_valid = |is_pend;
    assign fs_req_idx   = first_one(is_pend);
    assign fs_req_key   = key_q[fs_req_idx];

    sbst_buf_mem #(
        .DEPTH (NUM_BUFS),
        .WIDTH (DATA_W),
        .AW    (IDX_W)
    ) u_mem (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .we      (ev_apply && (ev_res == RES_DATA || ev_res == RES_LASTDATA ||
                   ev_res == RES_MOREDATA)),
        .waddr   (fs_ev_idx),
        .wdata   (fs_ev.data),
        .re      (cs_valid && cs_hit),
        .raddr   (cs_idx),
        .rdata_q (cs_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave: decode in setup, answer in the first access cycle

    logic [`SBST_ADDR_W-1:0] boff;
    logic                    buf_hit;
    logic [IDX_W-1:0]        bidx;
    logic [7:0]              pend_cnt;
    logic [7:0]              rdy_cnt;
    logic [31:0]             prdata_q;
    logic [31:0]             prdata_d;
    logic                    pslverr_q;
    logic                    pslverr_d;

    assign boff    = paddr - `SBST_OFF_BUF0;
    assign bidx    = boff[IDX_W+1:2];
    assign buf_hit = paddr >= `SBST_OFF_BUF0 && boff[1:0] == 2'h0 &&
                     boff[`SBST_ADDR_W-1:2] < (`SBST_ADDR_W-2)'(NUM_BUFS);

    always_comb begin
        pend_cnt = 8'h00;
        rdy_cnt  = 8'h00;
        for (int i = 0; i < NUM_BUFS; i++) begin
            pend_cnt = pend_cnt + {7'h00, is_pend[i]};
            rdy_cnt  = rdy_cnt + {7'h00, is_rdy[i]};
        end
    end

    always_comb begin
        ctrl_en_d = ctrl_en_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (psel && !penable) begin
            prdata_d  = 32'h0000_0000;
            pslverr_d = 1'b0;
            if (paddr == `SBST_OFF_CTRL) begin
                prdata_d[`SBST_CTRL_EN_BIT] = ctrl_en_q;
            end else if (paddr == `SBST_OFF_COUNT && !pwrite) begin
                prdata_d[`SBST_COUNT_PEND_LSB +: 8] = pend_cnt;
                prdata_d[`SBST_COUNT_RDY_LSB +: 8]  = rdy_cnt;
            end else if (buf_hit && !pwrite) begin
                prdata_d[`SBST_BUF_STAT_LSB +: 3] = stat_q[bidx];
                prdata_d[`SBST_BUF_RES_LSB +: 4]  = res_q[bidx];
                prdata_d[`SBST_BUF_KEY_LSB +: $bits(sbst_key_s)] = key_q[bidx];
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (psel && penable && pwrite && paddr == `SBST_OFF_CTRL) begin
            ctrl_en_d = pwdata[`SBST_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_en_q <= `SBST_CTRL_EN_RST;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            ctrl_en_q <= ctrl_en_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // a frozen block cannot finish a transfer, so ready follows ce
    assign pready  = ce;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ev(sbst_ev_e k);
        ce && ev_ok && fs_ev.kind == k && fs_ev.err == 8'h00;
    endsequence

    property p_ev_gives(sbst_ev_e k, sbst_res_e r);
        logic [IDX_W-1:0] i;
        (s_ev(k), i = fs_ev_idx) ##0 ev_apply |=>
            stat_q[i] == ST_READY && res_q[i] == r;
    endproperty

    property p_cs_old;
        logic [IDX_W-1:0] i;
        sbst_res_e        r;
        (ce && cs_take, i = cs_idx, r = res_q[cs_idx]) |=>
            stat_q[i] == ST_OLD && res_q[i] == r;
    endproperty

    property p_cs_reply;
        sbst_stat_e s;
        sbst_res_e  r;
        (ce && cs_valid && cs_hit, s = stat_q[cs_idx], r = res_q[cs_idx]) |=>
            cs_rsp_valid && cs_rsp_hit && cs_rsp.status == s && cs_rsp.result == r;
    endproperty

    a_reset_old: assert property (disable iff (1'b0)
        rst |=> stat_q[0] == ST_OLD && res_q[0] == RES_NONE && ctrl_en_q)
        else $error("buffer not old after reset");
    a_new_pending: assert property (
        ce && ss_take_new |=> stat_q[$past(ss_idx)] == ST_PENDING &&
        res_q[$past(ss_idx)] == RES_NONE)
        else $error("new start-split not pending");
    a_pend_holds: assert property (
        ce && is_pend[0] && !(ev_apply && fs_ev_idx == '0) |=> is_pend[0])
        else $error("pending buffer left without outcome");
    a_nak_ready: assert property (p_ev_gives(EV_NAK, RES_NAK))
        else $error("nak not recorded");
    a_ack_ready: assert property (p_ev_gives(EV_ACK, RES_ACK))
        else $error("ack not recorded");
    a_stall_ready: assert property (p_ev_gives(EV_STALL, RES_STALL))
        else $error("stall not recorded");
    a_data_ready: assert property (p_ev_gives(EV_DATA_OK, RES_DATA))
        else $error("bulk data not recorded");
    a_err_ready: assert property (
        ce && ev_ok && fs_ev.err != 8'h00 |=>
        stat_q[$past(fs_ev_idx)] == ST_READY && res_q[$past(fs_ev_idx)] == RES_TRANS_ERR)
        else $error("downstream error not recorded");
    a_last_data: assert property (p_ev_gives(EV_PKT_END, RES_LASTDATA))
        else $error("lastdata not recorded");
    a_more_data: assert property (p_ev_gives(EV_UFRAME, RES_MOREDATA))
        else $error("moredata not recorded");
    a_cs_old: assert property (p_cs_old)
        else $error("complete-split did not retire buffer");
    a_cs_reply: assert property (p_cs_reply)
        else $error("complete-split reply wrong");
    a_one_per_ep: assert property (
        ss_retry |-> !is_old[ss_idx] && ss_match[ss_idx] && !ss_take_new)
        else $error("second buffer for one endpoint");

endmodule // sbst_tracker

// ==== verification/sbst_host_model.sv ====
// host controller model: issues start- and complete-splits to the tracker
`timescale 1ns/1ps
module sbst_host_model import sbst_pkg::*; (
    input  wire logic       clk,       // system clock
    input  wire sbst_ss_e   ss_answer, // tracker reply to a start-split
    input  wire logic [0:0] ss_idx,    // buffer the tracker chose
    output logic            ss_valid,  // start-split strobe
    output sbst_key_s       ss_key,    // start-split endpoint key
    output logic            cs_valid,  // complete-split strobe
    output sbst_key_s       cs_key     // complete-split endpoint key
);
    initial begin
        ss_valid = 1'b0;
        cs_valid = 1'b0;
        ss_key   = '0;
        cs_key   = '0;
    end

    // reply is combinational; it is taken at the edge that accepts the offer
    task automatic start_split(input sbst_key_s k, output sbst_ss_e ans, output logic [0:0] ix);
        @(posedge clk);
        ss_valid <= 1'b1;
        ss_key   <= k;
        @(posedge clk);
        ans = ss_answer;
        ix  = ss_idx;
        ss_valid <= 1'b0;
        ss_key   <= sbst_key_s'(~k);
    endtask

    // released key lines flip so a stale key is never mistaken for a live one
    task automatic complete_split(input sbst_key_s k);
        @(posedge clk);
        cs_valid <= 1'b1;
        cs_key   <= k;
        @(posedge clk);
        cs_valid <= 1'b0;
        cs_key   <= sbst_key_s'(~k);
    endtask
endmodule // sbst_host_model

// ==== verification/sbst_tracker_tb_top.sv ====
// self-checking bench for the split buffer status tracker
`timescale 1ns/1ps
`include "sbst_defines.svh"
module sbst_tracker_tb_top;
    import sbst_pkg::*;
    localparam sbst_key_s KA = '{7'h05, 4'h1, 1'b1, EP_BULK, 1'b0};
    localparam sbst_key_s KL = '{7'h05, 4'h1, 1'b1, EP_BULK, 1'b1};
    localparam sbst_key_s KB = '{7'h06, 4'h2, 1'b0, EP_CTRL, 1'b0};
    localparam sbst_key_s KC = '{7'h07, 4'h3, 1'b1, EP_BULK, 1'b0};
    localparam sbst_key_s KI = '{7'h08, 4'h4, 1'b1, EP_INT, 1'b0};
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        fs_ev_valid = 1'b0;
    logic [0:0]  fs_ev_idx = 1'b0;
    sbst_fs_ev_s fs_ev = '0;
    logic [31:0] prdata, cs_data;
    logic        pready, pslverr, ss_valid, cs_valid, cs_rsp_valid, cs_rsp_hit, fs_req_valid;
    sbst_key_s   ss_key, cs_key, fs_req_key;
    sbst_ss_e    ss_answer;
    logic [0:0]  ss_idx, fs_req_idx;
    sbst_rsp_s   cs_rsp;
    int          fails = 0, n_tests = 0;

    always #20 clk = ~clk;

    sbst_tracker i_dut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ss_valid, .ss_key, .ss_answer, .ss_idx, .cs_valid, .cs_key,
        .cs_rsp_valid, .cs_rsp_hit, .cs_rsp, .cs_data, .fs_req_valid, .fs_req_idx,
        .fs_req_key, .fs_ev_valid, .fs_ev_idx, .fs_ev);
    sbst_host_model i_host (.clk, .ss_answer, .ss_idx, .ss_valid, .ss_key, .cs_valid, .cs_key);

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read data is only compared when no error is expected
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic experr);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            fails++;
            conclude();
        end
        chk({31'h0, pslverr}, {31'h0, experr});
        if (!w && !experr) chk(prdata, exp);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fs_event(input logic [0:0] i, input sbst_ev_e k, input logic [7:0] e,
                            input logic [31:0] d);
        @(posedge clk);
        fs_ev_valid <= 1'b1;
        fs_ev_idx   <= i;
        fs_ev       <= '{k, e, d};
        @(posedge clk);
        fs_ev_valid <= 1'b0;
        fs_ev       <= sbst_fs_ev_s'(~{k, e, d});
    endtask

    function automatic logic [31:0] bufw(sbst_stat_e s, sbst_res_e r, sbst_key_s k);
        return {9'h000, k, r, 1'b0, s};
    endfunction

    // one full life of a buffer: accept, pending, outcome, collect, old
    task automatic run_case(input sbst_key_s k, input sbst_ev_e ev, input logic [7:0] e,
                            input sbst_res_e r);
        sbst_ss_e    ans;
        logic [0:0]  ix;
        logic [7:0]  a;
        logic [31:0] d;
        d = 32'h5A5A_0000 ^ {24'h00_0000, e};
        i_host.start_split(k, ans, ix);
        a = `SBST_OFF_BUF0 + {5'h00, ix, 2'b00};
        chk(32'(ans), 32'(SS_ACK_NEW));
        acc(1'b0, a, '0, bufw(ST_PENDING, RES_NONE, k), 1'b0);
        chk({31'h0, fs_req_valid}, 32'h1);
        chk({16'h0, fs_req_key, fs_req_idx}, {16'h0, k, ix});
        fs_event(ix, ev, e, d);
        acc(1'b0, a, '0, bufw(ST_READY, r, k), 1'b0);
        i_host.complete_split(k);
        #1;
        chk({31'h0, cs_rsp_valid & cs_rsp_hit}, 32'h1);
        chk(32'(cs_rsp), 32'({ST_READY, r}));
        if (r inside {RES_DATA, RES_LASTDATA, RES_MOREDATA}) chk(cs_data, d);
        acc(1'b0, a, '0, bufw(ST_OLD, r, k), 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sbst_ss_e   ans;
        logic [0:0] ix;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, `SBST_OFF_BUF0, '0, bufw(ST_OLD, RES_NONE, '0), 1'b0);
        acc(1'b0, `SBST_OFF_BUF0 + 8'h04, '0, bufw(ST_OLD, RES_NONE, '0), 1'b0);
        acc(1'b0, `SBST_OFF_CTRL, '0, 32'h0000_0001, 1'b0);
        acc(1'b0, 8'h20, '0, '0, 1'b1);
        run_case(KA, EV_NAK, 8'h00, RES_NAK);
        run_case(KA, EV_ACK, 8'h00, RES_ACK);
        run_case(KA, EV_STALL, 8'h00, RES_STALL);
        run_case(KA, EV_DATA_OK, 8'h00, RES_DATA);
        run_case(KA, EV_ERR, 8'h00, RES_TRANS_ERR);
        for (int b = 0; b < 8; b++) run_case(KA, EV_ACK, 8'h01 << b, RES_TRANS_ERR);
        run_case(KI, EV_PKT_END, 8'h00, RES_LASTDATA);
        run_case(KI, EV_UFRAME, 8'h00, RES_MOREDATA);
        i_host.start_split(KA, ans, ix);
        chk(32'(ans), 32'(SS_ACK_NEW));
        i_host.start_split(KB, ans, ix);
        chk({28'h0, 2'(ans), 1'b0, ix}, 32'h0000_0005);
        i_host.start_split(KC, ans, ix);
        chk(32'(ans), 32'(SS_NAK));
        i_host.start_split(KL, ans, ix);
        chk({28'h0, 2'(ans), 1'b0, ix}, 32'h0000_0008);
        acc(1'b0, `SBST_OFF_COUNT, '0, 32'h0000_0002, 1'b0);
        fs_event(1'b1, EV_ACK, 8'h00, 32'h0000_0000);
        i_host.complete_split(KA);
        #1;
        chk(32'(cs_rsp), 32'({ST_PENDING, RES_NONE}));
        acc(1'b0, `SBST_OFF_COUNT, '0, 32'h0000_0101, 1'b0);
        i_host.complete_split(KB);
        #1;
        chk(32'(cs_rsp), 32'({ST_READY, RES_ACK}));
        acc(1'b1, `SBST_OFF_CTRL, 32'h0000_0000, '0, 1'b0);
        i_host.start_split(KC, ans, ix);
        chk(32'(ans), 32'(SS_NAK));
        acc(1'b1, `SBST_OFF_CTRL, 32'h0000_0001, '0, 1'b0);
        acc(1'b1, `SBST_OFF_COUNT, 32'h0000_0000, '0, 1'b1);
        // a frozen block must neither accept the offer nor answer the bus
        ce <= 1'b0;
        i_host.start_split(KC, ans, ix);
        chk({31'h0, pready}, 32'h0);
        ce <= 1'b1;
        acc(1'b0, `SBST_OFF_COUNT, '0, 32'h0000_0001, 1'b0);
        conclude();
    end

    // hang guard well beyond the longest sequence above
    initial begin
        #2_000_000;
        fails++;
        conclude();
    end
endmodule // sbst_tracker_tb_top
